// ### rtl/apc_pkg.sv
// Shared constants, types and coding function for the ADC control block
package apc_pkg;
  // Converter and lane geometry
  localparam int NUM_CH = 4;
  localparam int WORD_W = 10;
  localparam int MSB_IDX = 9;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] FIRST_IDX = 4'h0;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'h9;
  localparam logic [IDX_W-1:0] FRAME_HIGH_BITS = 4'h5;
  localparam logic [WORD_W-1:0] IDLE_WORD = 10'h000;

  // Clock rate and timing figures
  localparam int CLK_MHZ = 50;
  localparam logic [7:0] DCS_MIN_RATE_MHZ = 8'h14; // 20 MHz
  localparam int RELOCK_MAX_US = 5;
  localparam int STANDBY_WAKE_NS = 600;
  localparam logic [7:0] RELOCK_CYC = 8'(RELOCK_MAX_US * CLK_MHZ);
  localparam logic [7:0] STANDBY_WAKE_CYC =
    8'((STANDBY_WAKE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  typedef logic [WORD_W-1:0] apc_word_t;
  typedef apc_word_t [NUM_CH-1:0] apc_words_t;
  typedef enum logic [1:0] {DCS_OFF, DCS_RELOCK, DCS_LOCKED} apc_dcs_t;
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_STANDBY, PWR_WAKE, PWR_DOWN
  } apc_pwr_t;

  // Offset binary in, twos complement is offset binary with MSB flipped
  function automatic apc_word_t apc_encode(input apc_word_t w,
                                           input logic twos);
    return {w[MSB_IDX] ^ twos, w[MSB_IDX-1:0]};
  endfunction
endpackage

// ### rtl/apc_ctrl_if.sv
// Control bundle between the top and its stabilizer and power modules
`timescale 1ns/1ps
interface apc_ctrl_if;
  import apc_pkg::*;
  logic dcsEnable;
  logic [7:0] rateMhz;
  logic dcsLocked;
  logic powerDown;
  logic standbyReq;
  logic [NUM_CH-1:0] chanPdReq;
  logic refOn;
  logic pllOn;
  logic biasOn;
  logic driversOn;
  logic awake;
  logic [NUM_CH-1:0] chanOn;
  modport dcs (input dcsEnable, input rateMhz, output dcsLocked);
  modport pwr (input powerDown, input standbyReq, input chanPdReq,
    output refOn, output pllOn, output biasOn, output driversOn,
    output awake, output chanOn);
  modport ctl (output dcsEnable, output rateMhz, input dcsLocked,
    output powerDown, output standbyReq, output chanPdReq,
    input refOn, input pllOn, input biasOn, input driversOn,
    input awake, input chanOn);
endinterface

// ### rtl/apc_dcs_ctrl.sv
// Duty cycle stabilizer loop supervisor: rate gate and relock timing
`timescale 1ns/1ps
module apc_dcs_ctrl
  import apc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  apc_ctrl_if.dcs ctl
);
  apc_dcs_t state;
  logic [7:0] relockCnt;
  logic [7:0] lastRate;
  logic rateOk;

  assign rateOk = ctl.rateMhz >= DCS_MIN_RATE_MHZ;

  // Remember the rate so a dynamic change forces a relock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lastRate <= CNT_ZERO;
    end else begin
      lastRate <= ctl.rateMhz;
    end
  end

  // Loop state; unlocked means bypass, timing follows input duty cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= DCS_OFF;
      relockCnt <= CNT_ZERO;
    end else begin
      case (state)
        DCS_OFF: begin
          relockCnt <= CNT_ZERO;
          if (ctl.dcsEnable && rateOk) begin
            state <= DCS_RELOCK;
          end
        end
        DCS_RELOCK: begin
          relockCnt <= relockCnt + CNT_ONE;
          if (!ctl.dcsEnable || !rateOk) begin
            state <= DCS_OFF;
          end else if (ctl.rateMhz != lastRate) begin
            relockCnt <= CNT_ZERO;
          end else if (relockCnt == RELOCK_CYC - CNT_ONE) begin
            state <= DCS_LOCKED;
          end
        end
        DCS_LOCKED: begin
          relockCnt <= CNT_ZERO;
          if (!ctl.dcsEnable || !rateOk) begin
            state <= DCS_OFF;
          end else if (ctl.rateMhz != lastRate) begin
            state <= DCS_RELOCK;
          end
        end
        default: state <= DCS_OFF;
      endcase
    end
  end

  // Only a locked loop supplies the regenerated 50% edge
  assign ctl.dcsLocked = state == DCS_LOCKED;

  property p_dcs_slow;
    @(posedge mclk) disable iff (!rstn)
      !rateOk |=> !ctl.dcsLocked;
  endproperty
  a_dcs_slow: assert property (p_dcs_slow)
    else $error("stabilizer locked below minimum rate");

  property p_dcs_relock;
    @(posedge mclk) disable iff (!rstn)
      (ctl.rateMhz != lastRate) |=> !ctl.dcsLocked [*8];
  endproperty
  a_dcs_relock: assert property (p_dcs_relock)
    else $error("stabilizer claimed lock right after rate change");
endmodule

// ### rtl/apc_power_seq.sv
// Power sequencing: full power-down, standby and per-channel power-down
`timescale 1ns/1ps
module apc_power_seq
  import apc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  apc_ctrl_if.pwr ctl
);
  apc_pwr_t state;
  logic [7:0] wakeCnt;

  // Pin power-down outranks standby; config is held throughout
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= PWR_ACTIVE;
      wakeCnt <= CNT_ZERO;
    end else begin
      wakeCnt <= CNT_ZERO;
      case (state)
        PWR_ACTIVE: begin
          if (ctl.powerDown) begin
            state <= PWR_DOWN;
          end else if (ctl.standbyReq) begin
            state <= PWR_STANDBY;
          end
        end
        PWR_STANDBY: begin
          if (ctl.powerDown) begin
            state <= PWR_DOWN;
          end else if (!ctl.standbyReq) begin
            state <= PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          wakeCnt <= wakeCnt + CNT_ONE;
          if (ctl.powerDown) begin
            state <= PWR_DOWN;
          end else if (wakeCnt == STANDBY_WAKE_CYC - CNT_ONE) begin
            state <= PWR_ACTIVE;
          end
        end
        PWR_DOWN: begin
          // Analog wake-up after the pin falls is left to the system
          if (!ctl.powerDown) begin
            state <= PWR_ACTIVE;
          end
        end
        default: state <= PWR_ACTIVE;
      endcase
    end
  end

  // Enables derived from the power state
  assign ctl.refOn = state == PWR_ACTIVE || state == PWR_WAKE;
  assign ctl.biasOn = ctl.refOn;
  assign ctl.pllOn = state != PWR_DOWN;
  assign ctl.driversOn = state != PWR_DOWN;
  assign ctl.awake = state == PWR_ACTIVE;
  assign ctl.chanOn = ctl.awake ? ~ctl.chanPdReq : '0;

  property p_wake_time;
    @(posedge mclk) disable iff (!rstn)
      (state == PWR_STANDBY && !ctl.standbyReq && !ctl.powerDown)
        |=> !ctl.awake [*8] ##[20:24] ctl.awake;
  endproperty
  a_wake_time: assert property (p_wake_time)
    else $error("standby wake-up not near 600 ns");
endmodule

// ### rtl/apc_adc_control.sv
// Quad ADC control: power, stabilizer, coding and serial LVDS framing
`timescale 1ns/1ps
module apc_adc_control
  import apc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic powerDownPin,
  input wire logic outputModePin,
  input wire logic cfgDcsEnable,
  input wire logic [7:0] cfgRateMhz,
  input wire logic cfgStandby,
  input wire logic [NUM_CH-1:0] cfgChanPowerDown,
  input wire logic cfgLowSignal,
  input wire logic cfgExtraTerm,
  input wire logic cfgTwosComp,
  input wire apc_words_t sampleWord,
  output logic [NUM_CH-1:0] laneData,
  output logic [NUM_CH-1:0] laneOe,
  output logic bitClockOut,
  output logic bitClockOe,
  output logic frameClockOut,
  output logic frameClockOe,
  output logic lowSignalMode,
  output logic extraTermination,
  output logic refEnable,
  output logic pllEnable,
  output logic biasEnable,
  output logic [NUM_CH-1:0] channelPowered,
  output logic convClkStabilized,
  output logic dcsLocked,
  output logic deviceReady
);
  apc_ctrl_if ctl ();

  logic [1:0] rstPipe;
  logic rstn;
  logic [1:0] linkRstPipe;
  logic linkRstn;

  // Pins and serial-port config come from outside mclk: two flops each
  logic pdMeta, pdSync;
  logic modeMeta, modeSync;
  logic dcsEnMeta, dcsEnSync;
  logic stbyMeta, stbySync;
  logic lowMeta, lowSync;
  logic termMeta, termSync;
  logic twosMeta, twosSync;
  logic [7:0] rateMeta, rateSync;
  logic [NUM_CH-1:0] chPdMeta, chPdSync;

  // Word handshake between the sample domain and the link domain
  apc_words_t holdWord;
  logic reqMeta, reqSync, reqSeen;
  logic capture;
  logic reqTgl;
  logic ackMeta, ackSync;
  logic drvMeta, drvSync;
  logic [IDX_W-1:0] bitIdx;
  logic [IDX_W-1:0] next_bitIdx;
  logic loadWord;
  logic fresh;
  apc_words_t shiftWord;

  // Reset released through two flops in each domain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      linkRstPipe <= 2'h0;
    end else begin
      linkRstPipe <= {linkRstPipe[0], 1'b1};
    end
  end
  assign linkRstn = linkRstPipe[1];

  // Input synchronisers; configuration is quasi-static
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {pdMeta, pdSync, modeMeta, modeSync} <= 4'h0;
      {dcsEnMeta, dcsEnSync, stbyMeta, stbySync} <= 4'h0;
      {lowMeta, lowSync, termMeta, termSync} <= 4'h0;
      {twosMeta, twosSync} <= 2'h0;
      rateMeta <= CNT_ZERO;
      rateSync <= CNT_ZERO;
      chPdMeta <= '0;
      chPdSync <= '0;
    end else begin
      pdMeta <= powerDownPin;
      pdSync <= pdMeta;
      modeMeta <= outputModePin;
      modeSync <= modeMeta;
      dcsEnMeta <= cfgDcsEnable;
      dcsEnSync <= dcsEnMeta;
      stbyMeta <= cfgStandby;
      stbySync <= stbyMeta;
      lowMeta <= cfgLowSignal;
      lowSync <= lowMeta;
      termMeta <= cfgExtraTerm;
      termSync <= termMeta;
      twosMeta <= cfgTwosComp;
      twosSync <= twosMeta;
      rateMeta <= cfgRateMhz;
      rateSync <= rateMeta;
      chPdMeta <= cfgChanPowerDown;
      chPdSync <= chPdMeta;
    end
  end

  // Settings live in these flops, so power-down does not lose them
  assign ctl.dcsEnable = dcsEnSync;
  assign ctl.rateMhz = rateSync;
  assign ctl.powerDown = pdSync;
  assign ctl.standbyReq = stbySync;
  assign ctl.chanPdReq = chPdSync;

  apc_dcs_ctrl u_dcs (
    .mclk(mclk),
    .rstn(rstn),
    .ctl(ctl.dcs)
  );

  apc_power_seq u_pwr (
    .mclk(mclk),
    .rstn(rstn),
    .ctl(ctl.pwr)
  );

  // Registered status and analog enables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      refEnable <= 1'b0;
      pllEnable <= 1'b0;
      biasEnable <= 1'b0;
      channelPowered <= '0;
      dcsLocked <= 1'b0;
      convClkStabilized <= 1'b0;
      deviceReady <= 1'b0;
    end else begin
      refEnable <= ctl.refOn;
      pllEnable <= ctl.pllOn;
      biasEnable <= ctl.biasOn;
      channelPowered <= ctl.chanOn;
      dcsLocked <= ctl.dcsLocked;
      // Select regenerated edge only when locked, else follow input
      convClkStabilized <= ctl.dcsLocked;
      deviceReady <= ctl.awake;
    end
  end

  // Driver options: LVDS after reset, reduced by pin or config
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lowSignalMode <= 1'b0;
      extraTermination <= 1'b0;
    end else begin
      lowSignalMode <= modeSync | lowSync;
      extraTermination <= termSync;
    end
  end

  // Link asks for a word by toggling; capture it here once per request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
    end else begin
      reqMeta <= reqTgl;
      reqSync <= reqMeta;
    end
  end
  assign capture = reqSync != reqSeen;

  // Holding words stay still from capture until the next request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reqSeen <= 1'b0;
      holdWord <= '0;
    end else begin
      reqSeen <= reqSync;
      if (capture) begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
          // Powered-down lane carries idle zeros, clocks keep going
          holdWord[ch] <= ctl.chanOn[ch] ?
            apc_encode(sampleWord[ch], twosSync) :
            IDLE_WORD;
        end
      end
    end
  end

  // Link side sees the acknowledge and the driver enable through 2 flops
  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
      drvMeta <= 1'b0;
      drvSync <= 1'b0;
    end else begin
      ackMeta <= reqSeen;
      ackSync <= ackMeta;
      drvMeta <= ctl.driversOn;
      drvSync <= drvMeta;
    end
  end

  // Ten link edges per word; a late word is replaced by idle zeros
  assign loadWord = bitIdx == LAST_IDX;
  assign fresh = ackSync == reqTgl;
  assign next_bitIdx = loadWord ? FIRST_IDX : bitIdx + 4'h1;

  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      bitIdx <= LAST_IDX;
      reqTgl <= 1'b0;
    end else begin
      bitIdx <= next_bitIdx;
      if (loadWord && fresh) begin
        reqTgl <= ~reqTgl;
      end
    end
  end

  // Serializer, MSB first on each lane
  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      shiftWord <= '0;
      laneData <= '0;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (loadWord) begin
          shiftWord[ch] <= fresh ? holdWord[ch] : IDLE_WORD;
          laneData[ch] <= fresh ? holdWord[ch][MSB_IDX] : 1'b0;
        end else begin
          shiftWord[ch] <= shiftWord[ch] << 1;
          laneData[ch] <= shiftWord[ch][MSB_IDX-1];
        end
      end
    end
  end

  // Bit clock flips every bit, so both its edges carry data
  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      bitClockOut <= 1'b0;
      frameClockOut <= 1'b0;
    end else begin
      bitClockOut <= ~bitClockOut;
      frameClockOut <= next_bitIdx < FRAME_HIGH_BITS;
    end
  end

  // High impedance on every lane and clock during power-down
  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      laneOe <= '0;
      bitClockOe <= 1'b0;
      frameClockOe <= 1'b0;
    end else begin
      laneOe <= {NUM_CH{drvSync}};
      bitClockOe <= drvSync;
      frameClockOe <= drvSync;
    end
  end

  property p_coding;
    @(posedge mclk) disable iff (!rstn)
      capture && ctl.chanOn[0] |=> holdWord[0] == {$past(twosSync) ^
        $past(sampleWord[0][MSB_IDX]), $past(sampleWord[0][MSB_IDX-1:0])};
  endproperty
  a_coding: assert property (p_coding)
    else $error("captured word coding wrong");

  property p_chan_off;
    @(posedge mclk) disable iff (!rstn)
      capture && !ctl.chanOn[2] |=> holdWord[2] == IDLE_WORD;
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("powered-down channel still produced a sample");

  property p_pd_off;
    @(posedge mclk) disable iff (!rstn)
      $rose(pdSync) |-> ##[1:3] (!refEnable && !pllEnable && !biasEnable);
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("analog blocks not shut in power-down");

  property p_pd_exit;
    @(posedge mclk) disable iff (!rstn)
      $fell(pdSync) && !stbySync |-> ##[1:3] deviceReady;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("device did not resume after power-down pin fell");

  property p_low_sig;
    @(posedge mclk) disable iff (!rstn)
      modeSync |=> lowSignalMode;
  endproperty
  a_low_sig: assert property (p_low_sig)
    else $error("output-mode pin did not select reduced signalling");

  property p_frame;
    @(posedge linkClk) disable iff (!linkRstn)
      $rose(frameClockOut) |=> frameClockOut [*4] ##1
        !frameClockOut [*5] ##1 frameClockOut;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame clock not five high, five low");

  property p_bit_clk;
    @(posedge linkClk) disable iff (!linkRstn)
      $rose(frameClockOut) |-> ##10 $rose(frameClockOut) &&
        bitClockOut == $past(bitClockOut, 10);
  endproperty
  a_bit_clk: assert property (p_bit_clk)
    else $error("bit clock not five periods per word");

  property p_msb_first;
    @(posedge linkClk) disable iff (!linkRstn)
      loadWord && fresh |=> laneData[2] == $past(holdWord[2][MSB_IDX])
        ##1 laneData[2] == $past(holdWord[2][MSB_IDX-1], 2);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("lane did not send MSB first");

  property p_hiz;
    @(posedge linkClk) disable iff (!linkRstn)
      !drvSync |-> ##1 (laneOe == '0 && !bitClockOe && !frameClockOe);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("outputs driven during power-down");
endmodule

// ### testbench/apc_lvds_rx.sv
// Receiver model of the serial lanes: frame alignment and word capture
`timescale 1ns/1ps
module apc_lvds_rx
  import apc_pkg::*;
(
  input wire logic linkClk,
  input wire logic [NUM_CH-1:0] laneData,
  input wire logic bitClockOut,
  input wire logic frameClockOut,
  input wire logic frameClockOe,
  output apc_words_t rxWord,
  output int wordCount,
  output int badFrames
);
  apc_words_t shiftReg = '0;
  int bitCnt = 0;
  int highCnt = 0;
  int edgeCnt = 0;
  logic prevFrame = 1'b0;
  logic prevBit = 1'b0;
  logic started = 1'b0;

  // Nothing captured yet
  initial begin
    rxWord = '0;
    wordCount = 0;
    badFrames = 0;
  end

  // Falling link edge is mid-bit, halfway between two bit clock edges
  always @(negedge linkClk) begin
    prevFrame <= frameClockOut;
    prevBit <= bitClockOut;
    if (!frameClockOe) begin
      started <= 1'b0;
    end else if (frameClockOut && !prevFrame) begin
      // Ten bits, five of them frame-high, five bit clock periods
      if (started && (bitCnt != 10 || highCnt != 5
          || edgeCnt != 10)) begin
        badFrames <= badFrames + 1;
      end
      if (started) begin
        rxWord <= shiftReg;
        wordCount <= wordCount + 1;
      end
      started <= 1'b1;
      bitCnt <= 1;
      highCnt <= 1;
      edgeCnt <= int'(bitClockOut != prevBit);
      for (int n = 0; n < NUM_CH; n++) begin
        shiftReg[n] <= {9'h000, laneData[n]};
      end
    end else begin
      bitCnt <= bitCnt + 1;
      highCnt <= highCnt + int'(frameClockOut);
      edgeCnt <= edgeCnt + int'(bitClockOut != prevBit);
      // First bit ends on top, so the word arrives MSB first
      for (int n = 0; n < NUM_CH; n++) begin
        shiftReg[n] <= {shiftReg[n][8:0], laneData[n]};
      end
    end
  end
endmodule

// ### testbench/tb_adc_power_and_output_control.sv
// Self-checking bench for the ADC power, stabilizer and output block
`timescale 1ns/1ps
module tb_adc_power_and_output_control
  import apc_pkg::*;
;
  typedef struct {logic t; logic [9:0] w; logic [9:0] e;} apc_row_t;
  logic mclk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn = 1'b0;
  logic powerDownPin = 1'b0;
  logic outputModePin = 1'b0;
  logic cfgDcsEnable = 1'b0;
  logic [7:0] cfgRateMhz = 8'h32;
  logic cfgStandby = 1'b0;
  logic [NUM_CH-1:0] cfgChanPowerDown = 4'h0;
  logic cfgLowSignal = 1'b0;
  logic cfgExtraTerm = 1'b0;
  logic cfgTwosComp = 1'b0;
  apc_words_t sampleWord = '0;
  logic [NUM_CH-1:0] laneData, laneOe, channelPowered;
  logic bitClockOut, bitClockOe, frameClockOut, frameClockOe;
  logic lowSignalMode, extraTermination, refEnable, pllEnable;
  logic biasEnable, convClkStabilized, dcsLocked, deviceReady;
  apc_words_t rxWord;
  int wordCount, badFrames;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Offset binary rows, then twos complement rows (expected lane 0)
  apc_row_t rows [6] = '{
    '{1'b0, 10'h3ff, 10'h3ff}, '{1'b0, 10'h200, 10'h200},
    '{1'b0, 10'h000, 10'h000}, '{1'b1, 10'h3ff, 10'h1ff},
    '{1'b1, 10'h200, 10'h000}, '{1'b1, 10'h1ff, 10'h3ff}};

  apc_adc_control apc_adc_control_i (.mclk(mclk), .resetn(resetn),
    .linkClk(linkClk), .powerDownPin(powerDownPin),
    .outputModePin(outputModePin), .cfgDcsEnable(cfgDcsEnable),
    .cfgRateMhz(cfgRateMhz), .cfgStandby(cfgStandby),
    .cfgChanPowerDown(cfgChanPowerDown), .cfgLowSignal(cfgLowSignal),
    .cfgExtraTerm(cfgExtraTerm), .cfgTwosComp(cfgTwosComp),
    .sampleWord(sampleWord), .laneData(laneData), .laneOe(laneOe),
    .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
    .frameClockOut(frameClockOut), .frameClockOe(frameClockOe),
    .lowSignalMode(lowSignalMode), .extraTermination(extraTermination),
    .refEnable(refEnable), .pllEnable(pllEnable),
    .biasEnable(biasEnable), .channelPowered(channelPowered),
    .convClkStabilized(convClkStabilized), .dcsLocked(dcsLocked),
    .deviceReady(deviceReady));

  apc_lvds_rx apc_lvds_rx_i (.linkClk(linkClk), .laneData(laneData),
    .bitClockOut(bitClockOut), .frameClockOut(frameClockOut),
    .frameClockOe(frameClockOe), .rxWord(rxWord),
    .wordCount(wordCount), .badFrames(badFrames));

  // Sample clock
  always #10 mclk = ~mclk;

  // Link clock, offset so its edges never meet a check instant
  initial begin
    #7;
    forever #80 linkClk = ~linkClk;
  end

  // Hang guard, well above the expected run of some 4000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Checks land 1 ns after the edge so its updates have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic words(input int n);
    int target;
    target = wordCount + n;
    for (int i = 0; i < 3000 && wordCount < target; i++) begin
      cyc(1);
    end
  endtask

  // Reset must also span three link edges for the link-side sync
  task automatic doReset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    repeat (3) @(posedge linkClk);
    @(posedge mclk);
    resetn <= 1'b1;
  endtask

  // Odd lanes carry the inverted word; one-word pipeline needs 4 words
  task automatic load(input logic [9:0] w, input logic t);
    @(posedge mclk);
    cfgTwosComp <= t;
    for (int n = 0; n < NUM_CH; n++) begin
      sampleWord[n] <= n[0] ? ~w : w;
    end
    words(4);
  endtask

  task automatic lanes(input logic [9:0] e, input logic [3:0] off);
    for (int n = 0; n < NUM_CH; n++) begin
      chk(16'(rxWord[n]), off[n] ? 16'h0000 : {6'h00, n[0] ? ~e : e});
    end
  endtask

  task automatic dcs(input logic [7:0] r, input logic en, input int n,
                     input logic [1:0] e);
    @(posedge mclk);
    cfgRateMhz <= r;
    cfgDcsEnable <= en;
    cyc(n);
    chk(16'({dcsLocked, convClkStabilized}), 16'(e));
  endtask

  // Main sequence: table first, then reset and awkward cases
  initial begin
    doReset();
    foreach (rows[i]) begin
      load(rows[i].w, rows[i].t);
      lanes(rows[i].e, 4'h0);
    end
    doReset();
    #1;
    chk(16'({refEnable, deviceReady, laneOe, bitClockOe}), 16'h0000);
    cyc(10);
    chk(16'({lowSignalMode, extraTermination, dcsLocked, deviceReady,
      refEnable, pllEnable, biasEnable, channelPowered}), 16'h00ff);
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      outputModePin <= m[0];
      cfgLowSignal <= m[1];
      cfgExtraTerm <= m[1];
      cyc(6);
      chk(16'({lowSignalMode, extraTermination}),
        16'({m[0] | m[1], m[1]}));
    end
    @(posedge mclk);
    cfgChanPowerDown <= 4'h5;
    load(10'h155, 1'b0);
    chk(16'(channelPowered), 16'h000a);
    lanes(10'h155, 4'h5);
    @(posedge mclk);
    cfgChanPowerDown <= 4'h0;
    cfgStandby <= 1'b1;
    cyc(10);
    chk(16'({pllEnable, refEnable, biasEnable, deviceReady}),
      16'h0008);
    @(posedge mclk);
    cfgStandby <= 1'b0;
    cyc(20);
    chk(16'(deviceReady), 16'h0000);
    cyc(20);
    chk(16'(deviceReady), 16'h0001);
    dcs(8'h28, 1'b1, 200, 2'b00);
    dcs(8'h28, 1'b1, 70, 2'b11);
    dcs(8'h13, 1'b1, 300, 2'b00);
    dcs(8'h14, 1'b1, 10, 2'b00);
    dcs(8'h14, 1'b1, 260, 2'b11);
    dcs(8'h14, 1'b0, 8, 2'b00);
    load(10'h0f0, 1'b1);
    @(posedge mclk);
    powerDownPin <= 1'b1;
    cyc(8);
    chk(16'({refEnable, pllEnable, biasEnable, deviceReady}),
      16'h0000);
    repeat (6) @(posedge linkClk);
    cyc(1);
    chk(16'({laneOe, bitClockOe, frameClockOe}), 16'h0000);
    @(posedge mclk);
    powerDownPin <= 1'b0;
    // Wake-up allowance before trusting data again
    words(4);
    chk(16'({deviceReady, laneOe, bitClockOe, frameClockOe}),
      16'h007f);
    lanes(10'h2f0, 4'h0);
    chk(16'(badFrames), 16'h0000);
    conclude();
  end
endmodule
